/* verilog/nvm_regs_pkg.sv */
package nvm_regs_pkg;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [5:0] OFS_COMMAND_CONTROL = 6'h00;
  localparam logic [5:0] OFS_SECONDARY_CONTROL = 6'h04;
  localparam logic [5:0] OFS_MEMORY_PARAMETERS = 6'h08;
  localparam logic [5:0] OFS_INTERRUPT_ENABLE_CLEAR = 6'h0c;
  localparam logic [5:0] OFS_INTERRUPT_ENABLE_SET = 6'h10;
  localparam logic [5:0] OFS_INTERRUPT_FLAGS = 6'h14;
  localparam logic [5:0] OFS_STATUS_REGISTER = 6'h18;
  localparam logic [5:0] OFS_TARGET_ADDRESS = 6'h1c;
  localparam logic [5:0] OFS_REGION_LOCK_BITS = 6'h20;

  // ----------------------------------------------------------------
  // field layouts and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] EXECUTE_KEY = 8'ha5;
  localparam int CMD_CODE_W = 7;
  localparam int ADDR_W = 22;
  localparam int LOCK_W = 16;
  localparam logic [31:0] SECONDARY_CONTROL_RESET = 32'h0000_0080;
  localparam logic [31:0] SECONDARY_CONTROL_MASK = 32'h0007_008f;
  localparam int FLD_MANUAL_WRITE = 7;
  localparam int FLD_CACHE_DISABLE = 18;
  localparam int FLD_READ_MODE_LO = 16;
  localparam int FLD_PAGE_SIZE_LO = 16;
  localparam int INT_READY = 0;
  localparam int INT_ERROR = 1;
  localparam int ST_PRM = 0;
  localparam int ST_LOAD = 1;
  localparam int ST_PROG_ERR = 2;
  localparam int ST_LOCK_ERR = 3;
  localparam int ST_MEM_ERR = 4;

  // ----------------------------------------------------------------
  // command codes
  // ----------------------------------------------------------------
  localparam logic [6:0] CMD_ERASE_ROW = 7'h02;
  localparam logic [6:0] CMD_WRITE_PAGE = 7'h04;
  localparam logic [6:0] CMD_ERASE_AUX_ROW = 7'h05;
  localparam logic [6:0] CMD_WRITE_AUX_PAGE = 7'h06;
  localparam logic [6:0] CMD_LOCK_REGION = 7'h40;
  localparam logic [6:0] CMD_UNLOCK_REGION = 7'h41;
  localparam logic [6:0] CMD_SET_POWER_REDUCTION = 7'h42;
  localparam logic [6:0] CMD_CLEAR_POWER_REDUCTION = 7'h43;
  localparam logic [6:0] CMD_CLEAR_PAGE_BUFFER = 7'h44;
  localparam logic [6:0] CMD_SET_SECURITY = 7'h45;
  localparam logic [6:0] CMD_INVALIDATE_CACHE = 7'h46;

  typedef enum logic [1:0] {
    LAUNCH_IDLE = 2'b01,
    LAUNCH_WAIT = 2'b10
  } launch_state_t;

endpackage

/* verilog/launch_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface launch_if;
  logic issue;
  logic mem_access;
  logic array_busy;
  logic pending;
  logic launch;

  modport ctrl (output issue, output mem_access, output array_busy, input pending, input launch);
  modport seq (input issue, input mem_access, input array_busy, output pending, output launch);
endinterface

`default_nettype wire

/* verilog/command_launcher.sv */
`timescale 1ns/1ps
`default_nettype none

module command_launcher
  import nvm_regs_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // handshake with register bank
  launch_if.seq lnk
);

  launch_state_t state_reg;
  launch_state_t state_next;
  logic launch_next;
  wire logic both_idle = !lnk.mem_access && !lnk.array_busy;

  always_comb
  begin
    state_next = state_reg;
    launch_next = 1'b0;
    case (state_reg)
      LAUNCH_IDLE:
      begin
        if (lnk.issue)
          state_next = LAUNCH_WAIT;
      end
      LAUNCH_WAIT:
      begin
        // memory bus served first, array must be idle too
        if (both_idle)
        begin
          state_next = LAUNCH_IDLE;
          launch_next = 1'b1;
        end
      end
      default:
      begin
        state_next = LAUNCH_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= LAUNCH_IDLE;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign lnk.pending = (state_reg == LAUNCH_WAIT);
  // launch in the cycle the wait ends, so the start pulse follows one edge later
  assign lnk.launch = launch_next;

endmodule

`default_nettype wire

/* verilog/nvm_command_register_interface.sv */
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - a command runs only when the key byte is written with 0xa5.
// - a wrong key starts nothing and sets the programming error flag.
// - issuing while an earlier command is still pending or running sets the programming error flag.
// - a command issued in the same cycle as a memory-bus access waits behind that access.
// - a deferred command starts only once the array and the memory bus are both idle.
// - key bit 0 reads 1 from the key write until the command has been launched.
// - the target address field holds a halfword address.
// - 8, 16 and 32 bit register accesses are all supported atomically.
// - every byte and halfword of the secondary control and target address registers can be written without touching the rest.
// - the command register is 16 bits, key in 15:8, code in 6:0, reset zero.
// - erase row, write page, lock, unlock, clear page buffer, invalidate cache and others are decoded.
// - while the array works the ready flag is low and memory-bus accesses stall.
// - an erase row command aimed at a locked region is dropped and sets the lock error flag.
module nvm_command_register_interface
  import nvm_regs_pkg::*;
#(
  parameter int REGION_SHIFT = 18,
  parameter logic [15:0] PAGE_COUNT = 16'h0100,
  parameter logic [2:0] PAGE_SIZE_CODE = 3'h1,
  parameter logic [nvm_regs_pkg::LOCK_W-1:0] LOCK_RESET = 16'hffff
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // peripheral register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [5:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // memory bus side
  input wire logic mem_access,
  input wire logic mem_wr_valid,
  input wire logic [nvm_regs_pkg::ADDR_W:0] mem_wr_byte_addr,
  output logic mem_stall,
  // array side
  input wire logic array_busy,
  input wire logic page_loaded,
  input wire logic array_error,
  output logic cmd_start,
  output logic [nvm_regs_pkg::CMD_CODE_W-1:0] cmd_code,
  output logic [nvm_regs_pkg::ADDR_W-1:0] cmd_addr,
  output logic cache_invalidate,
  // configuration outputs
  output logic manual_write_select,
  output logic [3:0] read_wait_states,
  output logic cache_disable,
  output logic [1:0] read_mode_select,
  output logic power_reduction_flag,
  // interrupt
  output logic irq
);

  if (REGION_SHIFT < 4 || REGION_SHIFT > ADDR_W - 4)
  begin : bad_region_shift
    $error("region shift out of range");
  end

  // ----------------------------------------------------------------
  // byte lane merge
  // ----------------------------------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wr, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (be[i])
        r[8*i +: 8] = wr[8*i +: 8];
    return r;
  endfunction

  function automatic logic [3:0] region_of(input logic [ADDR_W-1:0] a);
    return a[REGION_SHIFT +: 4];
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [6:0] cmd_reg;
  logic [31:0] sec_ctrl_reg;
  logic [1:0] int_en_reg;
  logic prog_err_reg;
  logic lock_err_reg;
  logic mem_err_reg;
  logic prm_reg;
  logic error_flag_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [LOCK_W-1:0] lock_reg;
  logic [31:0] prdata_reg;
  logic [6:0] launch_code_reg;
  logic [ADDR_W-1:0] launch_addr_reg;

  launch_if lnk ();

  command_launcher u_launcher (
    .clk(clk),
    .rst_n(rst_n),
    .lnk(lnk)
  );

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire logic wr_en = psel && penable && pwrite;
  wire logic rd_setup = psel && !penable && !pwrite;
  wire logic sel_cmd = (paddr == OFS_COMMAND_CONTROL);
  wire logic sel_sec = (paddr == OFS_SECONDARY_CONTROL);
  wire logic sel_par = (paddr == OFS_MEMORY_PARAMETERS);
  wire logic sel_iec = (paddr == OFS_INTERRUPT_ENABLE_CLEAR);
  wire logic sel_ies = (paddr == OFS_INTERRUPT_ENABLE_SET);
  wire logic sel_ifl = (paddr == OFS_INTERRUPT_FLAGS);
  wire logic sel_sta = (paddr == OFS_STATUS_REGISTER);
  wire logic sel_adr = (paddr == OFS_TARGET_ADDRESS);
  wire logic sel_lck = (paddr == OFS_REGION_LOCK_BITS);
  wire logic mapped = sel_cmd | sel_sec | sel_par | sel_iec | sel_ies | sel_ifl | sel_sta | sel_adr | sel_lck;

  // ----------------------------------------------------------------
  // command issue
  // ----------------------------------------------------------------
  // code taken from the same write as the key when byte 0 is strobed, else the stored code
  wire logic [6:0] new_code = pstrb[0] ? pwdata[6:0] : cmd_reg;
  wire logic key_write = wr_en && sel_cmd && pstrb[1];
  wire logic key_ok = (pwdata[15:8] == EXECUTE_KEY);
  wire logic busy_now = lnk.pending || array_busy || cmd_start;
  wire logic code_known = (new_code == CMD_ERASE_ROW) || (new_code == CMD_WRITE_PAGE)
    || (new_code == CMD_ERASE_AUX_ROW) || (new_code == CMD_WRITE_AUX_PAGE)
    || (new_code >= CMD_LOCK_REGION && new_code <= CMD_INVALIDATE_CACHE);
  wire logic region_locked = !lock_reg[region_of(addr_reg)];
  wire logic erase_blocked = (new_code == CMD_ERASE_ROW) && region_locked;
  wire logic prog_err_set = key_write && (!key_ok || busy_now || !code_known);
  wire logic lock_err_set = key_write && key_ok && !busy_now && erase_blocked;
  wire logic issue = key_write && key_ok && !busy_now && code_known && !erase_blocked;

  assign lnk.issue = issue;
  assign lnk.mem_access = mem_access;
  assign lnk.array_busy = array_busy;

  wire logic launched = lnk.launch;
  wire logic [3:0] launch_region = region_of(launch_addr_reg);

  // ----------------------------------------------------------------
  // flags
  // ----------------------------------------------------------------
  wire logic ready_flag = !array_busy && !lnk.pending && !cmd_start;
  wire logic sta_clr = wr_en && sel_sta && pstrb[0];
  wire logic ifl_clr = wr_en && sel_ifl && pstrb[0] && pwdata[INT_ERROR];
  wire logic any_err_set = prog_err_set || lock_err_set || array_error;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prog_err_reg <= 1'b0;
      lock_err_reg <= 1'b0;
      mem_err_reg <= 1'b0;
      error_flag_reg <= 1'b0;
    end
    else
    begin
      // set wins over a clear in the same cycle
      prog_err_reg <= prog_err_set || (prog_err_reg && !(sta_clr && pwdata[ST_PROG_ERR]));
      lock_err_reg <= lock_err_set || (lock_err_reg && !(sta_clr && pwdata[ST_LOCK_ERR]));
      mem_err_reg <= array_error || (mem_err_reg && !(sta_clr && pwdata[ST_MEM_ERR]));
      error_flag_reg <= any_err_set || (error_flag_reg && !ifl_clr);
    end
  end

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  wire logic [31:0] sec_merged = merge(sec_ctrl_reg, pwdata, pstrb);
  wire logic [31:0] adr_merged = merge({{(32-ADDR_W){1'b0}}, addr_reg}, pwdata, pstrb);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cmd_reg <= 7'h00;
      sec_ctrl_reg <= SECONDARY_CONTROL_RESET;
      int_en_reg <= 2'b00;
      addr_reg <= '0;
    end
    else
    begin
      if (wr_en && sel_cmd && pstrb[0])
        cmd_reg <= pwdata[6:0];
      if (wr_en && sel_sec)
        sec_ctrl_reg <= sec_merged & SECONDARY_CONTROL_MASK;
      if (wr_en && sel_ies && pstrb[0])
        int_en_reg <= int_en_reg | pwdata[1:0];
      else if (wr_en && sel_iec && pstrb[0])
        int_en_reg <= int_en_reg & ~pwdata[1:0];
      // memory-bus writes record the halfword address
      if (mem_wr_valid)
        addr_reg <= mem_wr_byte_addr[ADDR_W:1];
      else if (wr_en && sel_adr)
        addr_reg <= adr_merged[ADDR_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // launch and command effects
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      launch_code_reg <= 7'h00;
      launch_addr_reg <= '0;
      cmd_start <= 1'b0;
      cmd_code <= 7'h00;
      cmd_addr <= '0;
      cache_invalidate <= 1'b0;
      lock_reg <= LOCK_RESET;
      prm_reg <= 1'b0;
    end
    else
    begin
      if (issue)
      begin
        launch_code_reg <= new_code;
        launch_addr_reg <= addr_reg;
      end
      cmd_start <= launched;
      cache_invalidate <= launched && (launch_code_reg == CMD_INVALIDATE_CACHE);
      if (launched)
      begin
        cmd_code <= launch_code_reg;
        cmd_addr <= launch_addr_reg;
        if (launch_code_reg == CMD_LOCK_REGION)
          lock_reg[launch_region] <= 1'b0;
        if (launch_code_reg == CMD_UNLOCK_REGION)
          lock_reg[launch_region] <= 1'b1;
        if (launch_code_reg == CMD_SET_POWER_REDUCTION)
          prm_reg <= 1'b1;
        if (launch_code_reg == CMD_CLEAR_POWER_REDUCTION)
          prm_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // key bit 0 shows an issued command not yet launched
  wire logic [31:0] rd_cmd = {16'h0000, 7'h00, lnk.pending, 1'b0, cmd_reg};
  wire logic [31:0] rd_par = {13'h0000, PAGE_SIZE_CODE, PAGE_COUNT};
  wire logic [31:0] rd_int = {30'h0, int_en_reg};
  wire logic [31:0] rd_ifl = {30'h0, error_flag_reg, ready_flag};
  wire logic [31:0] rd_sta = {27'h0, mem_err_reg, lock_err_reg, prog_err_reg, page_loaded, prm_reg};
  wire logic [31:0] rd_adr = {{(32-ADDR_W){1'b0}}, addr_reg};
  wire logic [31:0] rd_lck = {16'h0000, lock_reg};
  wire logic [31:0] rd_mux = sel_cmd ? rd_cmd : sel_sec ? sec_ctrl_reg : sel_par ? rd_par
    : (sel_iec || sel_ies) ? rd_int : sel_ifl ? rd_ifl : sel_sta ? rd_sta
    : sel_adr ? rd_adr : sel_lck ? rd_lck : 32'h0000_0000;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      prdata_reg <= 32'h0000_0000;
    else if (rd_setup)
      prdata_reg <= rd_mux;
  end

  assign prdata = prdata_reg;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign mem_stall = array_busy;
  assign manual_write_select = sec_ctrl_reg[FLD_MANUAL_WRITE];
  assign read_wait_states = sec_ctrl_reg[3:0];
  assign cache_disable = sec_ctrl_reg[FLD_CACHE_DISABLE];
  assign read_mode_select = sec_ctrl_reg[FLD_READ_MODE_LO +: 2];
  assign power_reduction_flag = prm_reg;
  assign irq = (ready_flag && int_en_reg[INT_READY]) || (error_flag_reg && int_en_reg[INT_ERROR]);

endmodule

`default_nettype wire

/* sim/nvm_cmd_asserts.sv */
`timescale 1ns/1ps
`default_nettype none

module nvm_cmd_asserts
  import nvm_regs_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [5:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  // memory bus and array
  input wire logic mem_access,
  input wire logic array_busy,
  input wire logic mem_stall,
  input wire logic cmd_start,
  input wire logic [nvm_regs_pkg::CMD_CODE_W-1:0] cmd_code,
  input wire logic cache_invalidate
);
  logic key_wr;
  logic good_key;
  logic keyed_reg;
  logic keyed_next;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // the execute key has been written and no launch has followed yet
  assign key_wr = psel && penable && pwrite && paddr == OFS_COMMAND_CONTROL && pstrb[1];
  assign good_key = key_wr && pwdata[15:8] == EXECUTE_KEY;
  assign keyed_next = cmd_start ? 1'b0 : (good_key ? 1'b1 : keyed_reg);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      keyed_reg <= 1'b0;
    else
      keyed_reg <= keyed_next;
  end

  a_start_single: assert property (cmd_start |=> !cmd_start)
    else $error("launch pulse longer than one cycle");
  a_start_needs_key: assert property (cmd_start |-> keyed_reg)
    else $error("launch without a key write");
  a_bad_key_quiet: assert property (key_wr && pwdata[15:8] != EXECUTE_KEY && !keyed_reg |=> !cmd_start [*3])
    else $error("launch after a wrong key");
  a_launch_mem_idle: assert property (cmd_start |-> !$past(mem_access))
    else $error("launch while memory bus busy");
  a_launch_array_idle: assert property (cmd_start |-> !$past(array_busy))
    else $error("launch while array busy");
  a_launch_latency: assert property (good_key && pstrb[0] && !keyed_reg && !array_busy && !cmd_start
    && (pwdata[6:0] == CMD_WRITE_PAGE || pwdata[6:0] == CMD_INVALIDATE_CACHE)
    ##1 (!mem_access && !array_busy) |=> cmd_start)
    else $error("idle launch not two cycles after key");
  a_stall_follows_busy: assert property (mem_stall == array_busy)
    else $error("stall differs from array busy");
  a_invalidate_pairs: assert property (cache_invalidate == (cmd_start && cmd_code == CMD_INVALIDATE_CACHE))
    else $error("cache invalidate not paired with its command");
endmodule

bind nvm_command_register_interface nvm_cmd_asserts u_nvm_cmd_asserts (
  .clk(clk),
  .rst_n(rst_n),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .pstrb(pstrb),
  .mem_access(mem_access),
  .array_busy(array_busy),
  .mem_stall(mem_stall),
  .cmd_start(cmd_start),
  .cmd_code(cmd_code),
  .cache_invalidate(cache_invalidate)
);

`default_nettype wire

/* sim/cpu_model.sv */
`timescale 1ns/1ps
`default_nettype none

module cpu_model
  import nvm_regs_pkg::*;
(
  // clock
  input wire logic clk,
  // register bus master
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [5:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  input wire logic pready
);
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 6'h00;
    pwdata = 32'h0;
    pstrb = 4'h0;
  end

  // setup, access held until ready, then release with scrambled lines
  task automatic xfer(input logic w, input logic [5:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk);
    #1;
    psel = 1'b1;
    pwrite = w;
    paddr = a;
    pwdata = d;
    pstrb = s;
    @(posedge clk);
    #1;
    penable = 1'b1;
    do
      @(posedge clk);
    while (!pready);
    #1;
    psel = 1'b0;
    penable = 1'b0;
    paddr = ~paddr;
    pwdata = ~pwdata;
  endtask

  task automatic issue(input logic [6:0] c, input logic [7:0] k);
    xfer(1'b1, OFS_COMMAND_CONTROL, {16'h0, k, 1'b0, c}, 4'h3);
  endtask
endmodule

`default_nettype wire

/* sim/nvm_command_register_interface_bench.sv */
`timescale 1ns/1ps
`default_nettype none

module nvm_command_register_interface_bench;
  import nvm_regs_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic mem_access = 1'b0;
  logic mem_wr_valid = 1'b0;
  logic [22:0] mem_wr_byte_addr = 23'h0;
  logic page_loaded = 1'b0;
  logic array_error = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, mem_stall, array_busy;
  logic cmd_start, cache_invalidate, manual_write_select, cache_disable, power_reduction_flag, irq;
  logic [5:0] paddr;
  logic [31:0] pwdata, prdata, exp_cfg;
  logic [3:0] pstrb, read_wait_states;
  logic [6:0] cmd_code;
  logic [21:0] cmd_addr;
  logic [1:0] read_mode_select;
  logic [32:0] rd_q[$];
  logic [29:0] cmd_q[$];
  logic [21:0] adr_exp = 22'h0;
  logic [6:0] codes[10] = '{7'h02, 7'h04, 7'h05, 7'h06, 7'h41, 7'h42, 7'h44, 7'h46, 7'h40, 7'h43};
  int bad_count = 0;
  int check_count = 0;
  int cycles = 0;
  int busy_cnt = 0;

  nvm_command_register_interface u_nvm_command_register_interface (
    .clk(clk),
    .rst_n(rst_n),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pstrb(pstrb),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .mem_access(mem_access),
    .mem_wr_valid(mem_wr_valid),
    .mem_wr_byte_addr(mem_wr_byte_addr),
    .mem_stall(mem_stall),
    .array_busy(array_busy),
    .page_loaded(page_loaded),
    .array_error(array_error),
    .cmd_start(cmd_start),
    .cmd_code(cmd_code),
    .cmd_addr(cmd_addr),
    .cache_invalidate(cache_invalidate),
    .manual_write_select(manual_write_select),
    .read_wait_states(read_wait_states),
    .cache_disable(cache_disable),
    .read_mode_select(read_mode_select),
    .power_reduction_flag(power_reduction_flag),
    .irq(irq)
  );
  cpu_model u_cpu_model (
    .clk(clk),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pstrb(pstrb),
    .pready(pready)
  );

  always #50 clk = ~clk;
  assign array_busy = busy_cnt != 0;

  // ----------------------------------------------------------------
  // array model, timeout and result monitor
  // ----------------------------------------------------------------
  always @(posedge clk)
  begin
    cycles = cycles + 1;
    if (psel && penable && !pwrite)
      chk({pslverr, prdata}, rd_q.size() != 0 ? rd_q.pop_front() : 'x, "read");
    if (cmd_start)
      chk({3'h0, cmd_addr, cache_invalidate, cmd_code}, cmd_q.size() != 0 ? {3'h0, cmd_q.pop_front()} : 'x, "launch");
    busy_cnt <= cmd_start ? 4 : (busy_cnt != 0 ? busy_cnt - 1 : 0);
    if (cycles == 20000)
    begin
      bad_count = bad_count + 1;
      complete_run();
    end
  end

  task automatic chk(input logic [32:0] got, input logic [32:0] exp, input string what);
    check_count = check_count + 1;
    if (got !== exp)
    begin
      bad_count = bad_count + 1;
      $display("unexpected %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic rd(input logic [5:0] a, input logic [32:0] e);
    rd_q.push_back(e);
    u_cpu_model.xfer(1'b0, a, 32'h0, 4'h0);
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [3:0] s);
    u_cpu_model.xfer(1'b1, a, d, s);
  endtask

  task automatic go(input logic [6:0] c, input logic [7:0] k, input logic launch);
    if (launch)
      cmd_q.push_back({adr_exp, c == CMD_INVALIDATE_CACHE, c});
    u_cpu_model.issue(c, k);
  endtask

  // looks only after the monitor and the array model have moved on
  task automatic wait_idle();
    for (int i = 0; i < 40 && (cmd_q.size() != 0 || array_busy); i++)
    begin
      @(posedge clk);
      #1;
    end
  endtask

  task automatic err_check(input logic [31:0] st);
    rd(OFS_STATUS_REGISTER, {1'b0, st});
    rd(OFS_INTERRUPT_FLAGS, 33'h3);
    wr(OFS_STATUS_REGISTER, 32'h1c, 4'h1);
    wr(OFS_INTERRUPT_FLAGS, 32'h2, 4'h1);
    rd(OFS_INTERRUPT_FLAGS, 33'h1);
  endtask

  task automatic complete_run();
    if (bad_count == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    logic [31:0] d;
    logic [3:0] s;
    void'($urandom(32'h680454d0));
    exp_cfg = SECONDARY_CONTROL_RESET;
    repeat (20) @(posedge clk);
    #1;
    rst_n = 1'b1;
    rd(OFS_COMMAND_CONTROL, 33'h0);
    rd(OFS_SECONDARY_CONTROL, {1'b0, SECONDARY_CONTROL_RESET});
    rd(OFS_MEMORY_PARAMETERS, 33'h0_0001_0100);
    rd(OFS_REGION_LOCK_BITS, 33'h0_0000_ffff);
    rd(6'h24, 33'h1_0000_0000);
    for (int i = 0; i < 8; i++)
    begin
      d = $urandom();
      s = 4'($urandom());
      for (int b = 0; b < 4; b++)
        if (s[b])
          exp_cfg[8*b +: 8] = d[8*b +: 8] & SECONDARY_CONTROL_MASK[8*b +: 8];
      wr(OFS_SECONDARY_CONTROL, d, s);
      rd(OFS_SECONDARY_CONTROL, {1'b0, exp_cfg});
      chk({25'h0, manual_write_select, read_wait_states, cache_disable, read_mode_select},
        {25'h0, exp_cfg[7], exp_cfg[3:0], exp_cfg[18], exp_cfg[17:16]}, "config");
    end
    d = $urandom();
    mem_wr_byte_addr = d[22:0];
    mem_wr_valid = 1'b1;
    @(posedge clk);
    #1;
    mem_wr_valid = 1'b0;
    mem_wr_byte_addr = ~mem_wr_byte_addr;
    rd(OFS_TARGET_ADDRESS, {11'h0, d[22:1]});
    wr(OFS_TARGET_ADDRESS, {14'h0, d[17:0]}, 4'hf);
    adr_exp = {4'h0, d[17:0]};
    foreach (codes[i])
    begin
      go(codes[i], EXECUTE_KEY, 1'b1);
      wait_idle();
      if (codes[i] == CMD_SET_POWER_REDUCTION || codes[i] == CMD_CLEAR_POWER_REDUCTION)
        chk({32'h0, power_reduction_flag}, {32'h0, codes[i] == CMD_SET_POWER_REDUCTION}, "power");
    end
    rd(OFS_REGION_LOCK_BITS, 33'h0_0000_fffe);
    go(CMD_WRITE_PAGE, 8'h5a, 1'b0);
    err_check(32'h4);
    go(CMD_ERASE_ROW, EXECUTE_KEY, 1'b0);
    err_check(32'h8);
    go(7'h10, EXECUTE_KEY, 1'b0);
    err_check(32'h4);
    mem_access = 1'b1;
    go(CMD_INVALIDATE_CACHE, EXECUTE_KEY, 1'b0);
    rd(OFS_COMMAND_CONTROL, 33'h0_0000_0146);
    wr(OFS_COMMAND_CONTROL, 32'h0000_a500, 4'h2);
    cmd_q.push_back({adr_exp, 1'b1, CMD_INVALIDATE_CACHE});
    mem_access = 1'b0;
    wait_idle();
    err_check(32'h4);
    rd(OFS_COMMAND_CONTROL, 33'h0_0000_0046);
    page_loaded = 1'b1;
    array_error = 1'b1;
    @(posedge clk);
    #1;
    array_error = 1'b0;
    err_check(32'h12);
    page_loaded = 1'b0;
    wr(OFS_INTERRUPT_ENABLE_SET, 32'h3, 4'h1);
    rd(OFS_INTERRUPT_ENABLE_SET, 33'h3);
    chk({32'h0, irq}, 33'h1, "irq");
    wr(OFS_INTERRUPT_ENABLE_CLEAR, 32'h1, 4'h1);
    chk({32'h0, irq}, 33'h0, "irq");
    go(CMD_WRITE_PAGE, 8'h00, 1'b0);
    chk({32'h0, irq}, 33'h1, "irq");
    err_check(32'h4);
    chk({32'h0, irq}, 33'h0, "irq");
    complete_run();
  end
endmodule

`default_nettype wire
